/* File: include/ptm_map.svh */
// register offsets, field positions, reset values and mode codes of the pulse timer control
`ifndef PTM_MAP_SVH
`define PTM_MAP_SVH

// register byte offsets (low address byte)
`define PTM_RUN_OFS 8'h00
`define PTM_MOD_OFS 8'h04
`define PTM_CFG_OFS 8'h08
`define PTM_CNT_OFS 8'h0c

// run control fields
`define PTM_RUN_BIT 0

// modulation control fields
`define PTM_CH1_CY_HI 11
`define PTM_CH1_CY_LO 9
`define PTM_CH1_RT_BIT 8
`define PTM_CH0_CY_HI 7
`define PTM_CH0_CY_LO 5
`define PTM_CH0_RT_BIT 4
`define PTM_PATH_BIT 2
`define PTM_AUX_HI 1
`define PTM_AUX_LO 0

// configuration fields
`define PTM_MODE_HI 2
`define PTM_MODE_LO 0
`define PTM_CLE_BIT 3

// reset values
`define PTM_MOD_RST 32'h0000_0000
`define PTM_CFG_RST 4'h0

// modulation cycle codes
`define PTM_CY_NONE 3'h0
`define PTM_CY_X16 3'h4

// operation mode codes
`define PTM_MODE_T1_PULSE 3'h1
`define PTM_MODE_T0_PULSE 3'h2
`define PTM_MODE_BOTH_PULSE 3'h3
`define PTM_MODE_LOCK_CH0 3'h6
`define PTM_MODE_LOCK_ALL 3'h7

`endif

/* File: include/ptm_pkg.sv */
// types shared by the pulse timer run and modulation control
package ptm_pkg;

  typedef logic [2:0] ptm_cycle_t;

  typedef struct packed {
    ptm_cycle_t ch1_cycle;
    logic ch1_reload_timing;
    ptm_cycle_t ch0_cycle;
    logic ch0_reload_timing;
    logic path_sel;
    logic [1:0] aux_sel;
  } ptm_mod_ctrl_t;

  typedef struct packed {
    logic write;
    logic [7:0] addr;
  } ptm_bus_req_t;

endpackage

/* File: verilog/ptm_ctrl.sv */
// pulse timer run control, modulation control and ahb-lite register slave
`timescale 1ns/1ps
`include "ptm_map.svh"

module ptm_ctrl
  import ptm_pkg::*;
#(
  parameter int TIMER_IDX = 0,
  parameter int CNT_W = 16
) (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // counting ticks and first timer state
  input wire logic own_prescaled_tick,
  input wire logic first_prescaled_clock,
  input wire logic first_timer_run,
  input wire logic first_path_sel,
  input wire logic first_overflow,
  input wire logic first_period_match,
  // own compare datapath events
  input wire logic period_match,
  input wire logic mod_step_ch0,
  input wire logic mod_step_ch1,
  input wire logic buffer_wr,
  // channel waveforms from the output logic
  input wire logic output_channel_zero,
  input wire logic output_channel_one,
  // counter and control results
  output logic [CNT_W-1:0] up_counter,
  output logic count_go,
  output logic counter_running,
  output logic path_sel_out,
  output ptm_cycle_t mod_cycle_ch0,
  output ptm_cycle_t mod_cycle_ch1,
  output logic reload_ch0,
  output logic reload_ch1,
  output logic direct_write,
  // pulse outputs
  output logic pulse_out_a0,
  output logic pulse_out_a1,
  output logic pulse_out_b0,
  output logic pulse_out_b1
);

  generate
    if (TIMER_IDX < 0 || TIMER_IDX > 1) begin : g_bad_idx
      $error("ptm_ctrl: TIMER_IDX must be 0 or 1");
    end
    if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
      $error("ptm_ctrl: CNT_W must lie in 2..32");
    end
  endgenerate

  localparam logic IS_SECOND = (TIMER_IDX == 1);
  localparam logic [31:0] MOD_RST_WORD = `PTM_MOD_RST;

  ptm_mod_ctrl_t mod_ctrl;
  logic [2:0] mode;
  logic clear_on_match;
  logic rt_act0;
  logic rt_act1;
  ptm_bus_req_t req;
  logic req_valid;

  // mode decode
  logic interlock;
  logic pulse_mode;
  logic follow_first;
  logic run_eff;
  logic tick_sel;
  logic path_eff;
  logic eff_rt0;
  logic eff_rt1;
  logic rt_load;

  always_comb begin
    interlock = (mode == `PTM_MODE_LOCK_CH0) || (mode == `PTM_MODE_LOCK_ALL);
    if (IS_SECOND) begin
      pulse_mode = interlock || (mode == `PTM_MODE_T1_PULSE) ||
                   (mode == `PTM_MODE_BOTH_PULSE);
    end else begin
      pulse_mode = interlock || (mode == `PTM_MODE_T0_PULSE) ||
                   (mode == `PTM_MODE_BOTH_PULSE);
    end
    follow_first = IS_SECOND && interlock;
    run_eff = follow_first ? first_timer_run : count_go;
    tick_sel = follow_first ? first_prescaled_clock : own_prescaled_tick;
    path_eff = follow_first ? first_path_sel : mod_ctrl.path_sel;
    eff_rt0 = (mod_ctrl.ch0_cycle == `PTM_CY_NONE) || rt_act0;
    eff_rt1 = (mod_ctrl.ch1_cycle == `PTM_CY_NONE) || rt_act1;
    rt_load = clear_on_match ? first_period_match : first_overflow;
  end

  // ahb-lite address phase capture; zero wait states, always okay
  logic accept;
  logic wr_en;
  logic [31:0] next_rdata;

  assign accept = ce && hsel && htrans[1] && hready;
  assign wr_en = ce && req_valid && req.write;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_valid <= 1'b0;
      req <= '0;
    end else if (ce) begin
      req_valid <= accept;
      if (accept) begin
        req.write <= hwrite;
        req.addr <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // read data is formed from the address phase so it stands in the data phase
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (haddr[7:0] == `PTM_RUN_OFS) begin
      next_rdata[`PTM_RUN_BIT] = counter_running;
    end else if (haddr[7:0] == `PTM_MOD_OFS) begin
      next_rdata[`PTM_CH1_CY_HI:`PTM_CH1_CY_LO] = mod_ctrl.ch1_cycle;
      next_rdata[`PTM_CH1_RT_BIT] = mod_ctrl.ch1_reload_timing;
      next_rdata[`PTM_CH0_CY_HI:`PTM_CH0_CY_LO] = mod_ctrl.ch0_cycle;
      next_rdata[`PTM_CH0_RT_BIT] = mod_ctrl.ch0_reload_timing;
      next_rdata[`PTM_PATH_BIT] = mod_ctrl.path_sel;
      next_rdata[`PTM_AUX_HI:`PTM_AUX_LO] = mod_ctrl.aux_sel;
    end else if (haddr[7:0] == `PTM_CFG_OFS) begin
      next_rdata[`PTM_MODE_HI:`PTM_MODE_LO] = mode;
      next_rdata[`PTM_CLE_BIT] = clear_on_match;
    end else if (haddr[7:0] == `PTM_CNT_OFS) begin
      next_rdata[CNT_W-1:0] = up_counter;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (accept && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // run bit register; bit 1 is write-zero only and is not stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_go <= 1'b0;
    end else if (wr_en && req.addr == `PTM_RUN_OFS) begin
      count_go <= hwdata[`PTM_RUN_BIT];
    end
  end

  // modulation control; prohibited cycle codes are stored as written
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mod_ctrl.ch1_cycle <= MOD_RST_WORD[`PTM_CH1_CY_HI:`PTM_CH1_CY_LO];
      mod_ctrl.ch1_reload_timing <= MOD_RST_WORD[`PTM_CH1_RT_BIT];
      mod_ctrl.ch0_cycle <= MOD_RST_WORD[`PTM_CH0_CY_HI:`PTM_CH0_CY_LO];
      mod_ctrl.ch0_reload_timing <= MOD_RST_WORD[`PTM_CH0_RT_BIT];
      mod_ctrl.path_sel <= MOD_RST_WORD[`PTM_PATH_BIT];
      mod_ctrl.aux_sel <= MOD_RST_WORD[`PTM_AUX_HI:`PTM_AUX_LO];
    end else if (wr_en && req.addr == `PTM_MOD_OFS) begin
      mod_ctrl.ch1_cycle <= hwdata[`PTM_CH1_CY_HI:`PTM_CH1_CY_LO];
      mod_ctrl.ch1_reload_timing <= hwdata[`PTM_CH1_RT_BIT];
      mod_ctrl.ch0_cycle <= hwdata[`PTM_CH0_CY_HI:`PTM_CH0_CY_LO];
      mod_ctrl.ch0_reload_timing <= hwdata[`PTM_CH0_RT_BIT];
      mod_ctrl.path_sel <= hwdata[`PTM_PATH_BIT];
      mod_ctrl.aux_sel <= hwdata[`PTM_AUX_HI:`PTM_AUX_LO];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {clear_on_match, mode} <= `PTM_CFG_RST;
    end else if (wr_en && req.addr == `PTM_CFG_OFS) begin
      mode <= hwdata[`PTM_MODE_HI:`PTM_MODE_LO];
      clear_on_match <= hwdata[`PTM_CLE_BIT];
    end
  end

  // reload timing only reaches the compare logic at a period boundary,
  // so a change mid-period cannot split one modulation frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rt_act0 <= 1'b0;
      rt_act1 <= 1'b0;
    end else if (ce && rt_load) begin
      rt_act0 <= mod_ctrl.ch0_reload_timing;
      rt_act1 <= mod_ctrl.ch1_reload_timing;
    end
  end

  // up-counter: run bit acts on the count only on a counting tick; counter_running samples it every enabled cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      up_counter <= '0;
      counter_running <= 1'b0;
    end else if (ce) begin
      counter_running <= run_eff;
      if (tick_sel) begin
        if (run_eff) begin
          up_counter <= up_counter + CNT_W'(1);
        end else begin
          up_counter <= '0;
        end
      end
    end
  end

  // modulation outputs and compare reload strobes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mod_cycle_ch0 <= `PTM_CY_NONE;
      mod_cycle_ch1 <= `PTM_CY_NONE;
      reload_ch0 <= 1'b0;
      reload_ch1 <= 1'b0;
      direct_write <= 1'b0;
      path_sel_out <= 1'b0;
    end else if (ce) begin
      mod_cycle_ch0 <= pulse_mode ? mod_ctrl.ch0_cycle : `PTM_CY_NONE;
      mod_cycle_ch1 <= pulse_mode ? mod_ctrl.ch1_cycle : `PTM_CY_NONE;
      reload_ch0 <= pulse_mode && path_eff &&
                    (eff_rt0 ? period_match : mod_step_ch0);
      reload_ch1 <= pulse_mode && path_eff &&
                    (eff_rt1 ? period_match : mod_step_ch1);
      direct_write <= buffer_wr && !path_eff;
      path_sel_out <= path_eff;
    end
    // a low enable holds the strobes too; the consumer gates them with the same enable
  end

  // each timer owns one pair of pulse pins; the other pair stays low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_out_a0 <= 1'b0;
      pulse_out_a1 <= 1'b0;
      pulse_out_b0 <= 1'b0;
      pulse_out_b1 <= 1'b0;
    end else if (ce) begin
      pulse_out_a0 <= !IS_SECOND && output_channel_zero;
      pulse_out_a1 <= !IS_SECOND && output_channel_one;
      pulse_out_b0 <= IS_SECOND && output_channel_zero;
      pulse_out_b1 <= IS_SECOND && output_channel_one;
    end
  end

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_stop_clears;
    (ce && tick_sel && !run_eff) |=> (up_counter == '0);
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("counter not cleared");

  property p_run_counts;
    (ce && tick_sel && run_eff) |=> (up_counter == $past(up_counter) + CNT_W'(1));
  endproperty
  a_run_counts: assert property (p_run_counts) else $error("counter did not step");

  property p_hold_between_ticks;
    (ce && !tick_sel) |=> $stable(up_counter);
  endproperty
  a_hold_between_ticks: assert property (p_hold_between_ticks) else $error("count moved");

  property p_second_follows;
    (ce && follow_first) |=> (counter_running == $past(first_timer_run));
  endproperty
  a_second_follows: assert property (p_second_follows) else $error("run not followed");

  property p_fields_idle;
    (ce && !pulse_mode) |=> (mod_cycle_ch0 == `PTM_CY_NONE && mod_cycle_ch1 == `PTM_CY_NONE
                             && !reload_ch0 && !reload_ch1);
  endproperty
  a_fields_idle: assert property (p_fields_idle) else $error("fields act outside pulse");

  property p_match_reload;
    (ce && pulse_mode && path_eff && eff_rt1 && period_match) |=> reload_ch1;
  endproperty
  a_match_reload: assert property (p_match_reload) else $error("no reload on match");

  property p_direct_no_reload;
    (ce && !path_eff) |=> (!reload_ch0 && !reload_ch1);
  endproperty
  a_direct_no_reload: assert property (p_direct_no_reload) else $error("reload on direct");

  property p_none_ignores_step;
    (ce && mod_ctrl.ch1_cycle == `PTM_CY_NONE && !period_match) |=> !reload_ch1;
  endproperty
  a_none_ignores_step: assert property (p_none_ignores_step) else $error("step reload");

  property p_rt_overflow;
    (ce && !clear_on_match && first_overflow) |=>
      (rt_act1 == $past(mod_ctrl.ch1_reload_timing));
  endproperty
  a_rt_overflow: assert property (p_rt_overflow) else $error("timing not loaded");

  property p_rt_match_only;
    (ce && clear_on_match && !first_period_match) |=> $stable(rt_act0) && $stable(rt_act1);
  endproperty
  a_rt_match_only: assert property (p_rt_match_only) else $error("timing loaded early");

  property p_direct_write;
    (ce && buffer_wr && !path_eff) |=>
      direct_write ##1 (!direct_write || $past(!ce || (buffer_wr && !path_eff)));
  endproperty
  a_direct_write: assert property (p_direct_write) else $error("direct write missing");

  property p_pin_route;
    ce |=> (pulse_out_a0 == (!IS_SECOND && $past(output_channel_zero)) &&
            pulse_out_b1 == (IS_SECOND && $past(output_channel_one)));
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("pulse pin routing");

  c_wrap: cover property (ce && tick_sel && run_eff && up_counter == '1);
  c_reload_match: cover property (reload_ch1 && eff_rt1);
  c_direct: cover property (direct_write);
  c_follow: cover property (follow_first && $rose(counter_running));

endmodule // ptm_ctrl

/* File: sim/tb.sv */
// self-checking bench for the pulse timer run and modulation control
`timescale 1ns/1ps
`include "ptm_map.svh"

module tb import ptm_pkg::*;;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, a0, a1, b0, b1, reload_ch0, reload_ch1, direct_write, cgo, crun, cpath;
  logic [31:0] hrdata;
  logic [15:0] up_counter;
  ptm_cycle_t mod_cycle_ch0, mod_cycle_ch1;
  logic tick = 1'b0, ftick = 1'b0, frun = 1'b0, fpath = 1'b0, fovf = 1'b0, fpm = 1'b0;
  logic pm = 1'b0, s0 = 1'b0, s1 = 1'b0, bw = 1'b0, chz = 1'b0, cho = 1'b0;
  logic rd_pend = 1'b0, st_pend = 1'b0;
  logic [31:0] rd_q[$];
  logic [31:0] st_q[$];
  logic [31:0] st_exp;
  logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  logic [2:0] mode, cyc0, cyc1;
  logic cle, path, fp, stg0, stg1, go, frv, act0 = 1'b0, act1 = 1'b0;
  logic [15:0] cnt = 16'h0;
  logic [31:0] r;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 1366;

  always #10 hclk = ~hclk;

  ptm_ctrl #(.TIMER_IDX(1), .CNT_W(16)) ptm_ctrl_i (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .own_prescaled_tick(tick), .first_prescaled_clock(ftick), .first_timer_run(frun),
    .first_path_sel(fpath), .first_overflow(fovf), .first_period_match(fpm),
    .period_match(pm), .mod_step_ch0(s0), .mod_step_ch1(s1), .buffer_wr(bw),
    .output_channel_zero(chz), .output_channel_one(cho), .up_counter(up_counter),
    .count_go(cgo), .counter_running(crun), .path_sel_out(cpath), .mod_cycle_ch0(mod_cycle_ch0),
    .mod_cycle_ch1(mod_cycle_ch1), .reload_ch0(reload_ch0), .reload_ch1(reload_ch1),
    .direct_write(direct_write), .pulse_out_a0(a0), .pulse_out_a1(a1),
    .pulse_out_b0(b0), .pulse_out_b1(b1));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, ofs};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? wd : 32'h0;
    rd_pend <= ~wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_pend <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    bus(1'b1, ofs, d);
  endtask

  task automatic rd(input logic [7:0] ofs, input logic [31:0] exp);
    rd_q.push_back(exp);
    bus(1'b0, ofs, 32'h0);
  endtask

  // one tick on the own counting input, or one on the first timer's counting input followed by one on the own
  task automatic pulse(input logic first);
    @(posedge hclk);
    tick <= ~first;
    ftick <= first;
    @(posedge hclk);
    tick <= first;
    ftick <= 1'b0;
    @(posedge hclk);
    tick <= 1'b0;
  endtask

  // v = own tick, first tick, period match, step ch0, step ch1, buffer write, ch zero, ch one
  task automatic window(input logic [7:0] v);
    logic pls;
    logic lk;
    logic pth;
    logic run;
    logic bwv;
    pls = mode inside {3'h1, 3'h3, 3'h6, 3'h7};
    lk = (mode[2:1] == 2'h3);
    pth = lk ? fp : path;
    run = lk ? frv : go;
    bwv = v[2] & pls;
    if (lk ? v[6] : v[7]) cnt = run ? cnt + 16'h1 : 16'h0;
    @(posedge hclk);
    {tick, ftick, pm, s0, s1, bw, chz, cho} <= {v[7:3], bwv, v[1:0]};
    @(posedge hclk);
    {tick, ftick, pm, s0, s1, bw} <= 6'h0;
    st_q.push_back({go, run, pth, cnt,
                    pls & pth & ((cyc0 == 3'h0 || act0) ? v[5] : v[4]),
                    pls & pth & ((cyc1 == 3'h0 || act1) ? v[5] : v[3]),
                    bwv & ~pth, pls ? cyc0 : 3'h0, pls ? cyc1 : 3'h0, 2'h0, v[1:0]});
    st_pend <= 1'b1;
    @(posedge hclk);
    st_pend <= 1'b0;
  endtask

  always @(posedge hclk) begin
    if (rd_pend && hreadyout === 1'b1) begin
      check({31'h0, hresp}, 32'h0);
      check(hrdata, rd_q.pop_front());
    end
    if (st_pend) begin
      st_exp = st_q.pop_front();
      check({13'h0, cgo, crun, cpath, up_counter}, {13'h0, st_exp[31:13]});
      check({19'h0, reload_ch0, reload_ch1, direct_write, mod_cycle_ch0, mod_cycle_ch1, a0, a1,
             b0, b1}, {19'h0, st_exp[12:0]});
    end
    cycles++;
    if (cycles == 5000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`PTM_MOD_OFS, `PTM_MOD_RST);
    rd(`PTM_CFG_OFS, 32'h0);
    rd(`PTM_CNT_OFS, 32'h0);
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, 32'h0);
    wr(`PTM_CFG_OFS, {29'h0, `PTM_MODE_T1_PULSE});
    wr(`PTM_RUN_OFS, 32'h1);
    repeat (5) pulse(1'b0);
    rd(`PTM_CNT_OFS, 32'h5);
    rd(`PTM_RUN_OFS, 32'h1);
    wr(`PTM_RUN_OFS, 32'h0);
    // the clear waits for the next counting tick, so the old count still reads back
    rd(`PTM_CNT_OFS, 32'h5);
    pulse(1'b0);
    rd(`PTM_CNT_OFS, 32'h0);
    repeat (2) pulse(1'b0);
    rd(`PTM_CNT_OFS, 32'h0);
    wr(`PTM_CFG_OFS, {29'h0, `PTM_MODE_LOCK_CH0});
    frun <= 1'b1;
    repeat (4) pulse(1'b1);
    rd(`PTM_RUN_OFS, 32'h1);
    rd(`PTM_CNT_OFS, 32'h4);
    // a low enable freezes the counter even across a counting tick
    ce <= 1'b0;
    pulse(1'b1);
    ce <= 1'b1;
    rd(`PTM_CNT_OFS, 32'h4);
    wr(`PTM_RUN_OFS, 32'h1);
    frun <= 1'b0;
    pulse(1'b1);
    rd(`PTM_RUN_OFS, 32'h0);
    rd(`PTM_CNT_OFS, 32'h0);
    for (int i = 0; i < 60; i++) begin
      r = $random(seed);
      mode = modes[r[2:0] % 6];
      {cle, path, fp, stg0, stg1} = r[7:3];
      cyc0 = 3'(r[10:8] % 5);
      cyc1 = 3'(r[13:11] % 5);
      // the bench's own ch0 fields stand in for the first timer's ch0 settings
      if (mode == `PTM_MODE_LOCK_ALL) begin
        cyc1 = cyc0;
        stg1 = stg0;
      end
      go = r[28];
      frv = r[29];
      fpath <= fp;
      frun <= frv;
      wr(`PTM_RUN_OFS, {31'h0, go});
      wr(`PTM_CFG_OFS, {28'h0, cle, mode});
      rd(`PTM_CFG_OFS, {28'h0, cle, mode});
      wr(`PTM_MOD_OFS, {r[31:20], 8'h0, cyc1, stg1, cyc0, stg0, r[14], path, r[16:15]});
      rd(`PTM_MOD_OFS, {20'h0, cyc1, stg1, cyc0, stg0, 1'b0, path, r[16:15]});
      @(posedge hclk);
      fovf <= r[17];
      fpm <= ~r[17];
      @(posedge hclk);
      fovf <= 1'b0;
      fpm <= 1'b0;
      if (r[17] != cle) begin
        act0 = stg0;
        act1 = stg1;
      end
      window(r[25:18]);
    end
    conclude();
  end
endmodule // tb
